// ### rtl/nvs_seq.sv
`timescale 1ns/100ps
// Functional notes
// - Skip power-down or pin store when clean
// - Writes still accepted 25 ns after trigger
// - Ignore reads, writes during copy, low supply
// - Lock I/O; store 8 ms, recall 600 us
// - Act on command within 500 us
// - Enter sleep within 8 ms
// - Ready 40/20 ms after leaving sleep
// - Standby within 100 us after STOP
// - Resume within 5 us of busy high
// - Drive busy line high at most 500 ns
// - External busy low disables SRAM, driver off
module nvs_seq import nvs_pkg::*; #(
	parameter bit LOW_V_VARIANT = 1'b0,
	parameter int STORE_CYC = NVS_STORE_CYC,
	parameter int RECALL_CYC = NVS_RECALL_CYC,
	parameter int WAKE_CYC = LOW_V_VARIANT ? NVS_WAKE_LV_CYC : NVS_WAKE_CYC
) (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic link_clk_in,
	input wire logic cmd_valid_in,
	input wire logic [1:0] cmd_code_in,
	input wire logic stop_in,
	input wire logic sram_wr_in,
	input wire logic vcc_low_in,
	input wire logic hw_store_busy_line_in,
	output logic hw_store_busy_line_out,
	output logic hw_store_busy_line_oe_b_out,
	output logic sram_rd_en_out,
	output logic sram_wr_en_out,
	output logic io_lockout_out,
	output logic nv_store_out,
	output logic nv_recall_out,
	output logic standby_out,
	output logic sleep_out,
	output logic link_busy_out
);
	// ----------------------------------------------------------------
	// Link domain: reset, command capture, busy feedback
	// ----------------------------------------------------------------
	logic lrst_meta;
	logic lrst_b;
	logic [1:0] cmd_hold;
	logic busy_meta;

	// Link reset is applied and released on link edges, so the link clock must run during reset
	always_ff @(posedge link_clk_in) begin
		lrst_meta <= rst_b_in;
		lrst_b <= lrst_meta;
	end

	// Code is held until the next command, so it is stable when sampled
	always_ff @(posedge link_clk_in) begin
		if (!lrst_b) cmd_hold <= NVS_CMD_ACCESS;
		else if (cmd_valid_in) cmd_hold <= cmd_code_in;
	end

	// Lockout level returned to the link side
	always_ff @(posedge link_clk_in) begin
		if (!lrst_b) begin
			busy_meta <= 1'b0;
			link_busy_out <= 1'b0;
		end else begin
			busy_meta <= io_lockout_out;
			link_busy_out <= busy_meta;
		end
	end

	// ----------------------------------------------------------------
	// Crossings into the system domain
	// ----------------------------------------------------------------
	logic cmd_evt;
	logic stop_evt;
	logic wr_evt;

	nvs_evt_sync u_cmd_sync (
		.src_clk_in(link_clk_in),
		.src_rst_b_in(lrst_b),
		.src_pulse_in(cmd_valid_in),
		.dst_clk_in(sys_clk_in),
		.dst_rst_b_in(rst_b_in),
		.dst_pulse_out(cmd_evt)
	);
	nvs_evt_sync u_stop_sync (
		.src_clk_in(link_clk_in),
		.src_rst_b_in(lrst_b),
		.src_pulse_in(stop_in),
		.dst_clk_in(sys_clk_in),
		.dst_rst_b_in(rst_b_in),
		.dst_pulse_out(stop_evt)
	);
	nvs_evt_sync u_wr_sync (
		.src_clk_in(link_clk_in),
		.src_rst_b_in(lrst_b),
		.src_pulse_in(sram_wr_in),
		.dst_clk_in(sys_clk_in),
		.dst_rst_b_in(rst_b_in),
		.dst_pulse_out(wr_evt)
	);

	// Pin levels pass two flops before use
	logic vlow_meta;
	logic vlow;
	logic vlow_d;
	logic busy_pin_meta;
	logic busy_pin;
	logic [1:0] cmd_meta;
	logic [1:0] cmd_code;

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			vlow_meta <= 1'b0;
			vlow <= 1'b0;
			vlow_d <= 1'b0;
			busy_pin_meta <= 1'b1;
			busy_pin <= 1'b1;
			cmd_meta <= NVS_CMD_ACCESS;
			cmd_code <= NVS_CMD_ACCESS;
		end else begin
			vlow_meta <= vcc_low_in;
			vlow <= vlow_meta;
			vlow_d <= vlow;
			busy_pin_meta <= hw_store_busy_line_in;
			busy_pin <= busy_pin_meta;
			cmd_meta <= cmd_hold;
			cmd_code <= cmd_meta;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	nvs_state_t st;
	nvs_state_t next_st;
	logic [NVS_CNT_W-1:0] cnt;
	logic dirty;
	logic drive_low;

	// Line held low by someone else: our driver is off while we see it
	wire busy_ext_low = !busy_pin && hw_store_busy_line_oe_b_out;
	wire auto_req = vlow && !vlow_d;
	wire sw_store = cmd_evt && cmd_code == NVS_CMD_STORE;
	wire sw_recall = cmd_evt && cmd_code == NVS_CMD_RECALL;
	wire sw_sleep = cmd_evt && cmd_code == NVS_CMD_SLEEP;
	wire trig_req = auto_req || busy_ext_low;
	// Nothing written since the last copy: trigger starts no store
	wire trig_store = trig_req && dirty;
	wire cnt_end_store = cnt == NVS_CNT_W'(STORE_CYC - 1);
	wire cnt_end_recall = cnt == NVS_CNT_W'(RECALL_CYC - 1);
	wire cnt_end_wake = cnt == NVS_CNT_W'(WAKE_CYC - 1);
	wire cnt_end_hhhd = cnt == NVS_CNT_W'(NVS_HHHD_CYC - 1);
	wire copy_start = next_st != st &&
		(next_st == NVS_GRACE || next_st == NVS_RECALL ||
		(next_st == NVS_STORE && st == NVS_IDLE));

	// Next state
	always_comb begin
		next_st = st;
		unique case (st)
			NVS_IDLE: begin
				if (trig_store) next_st = NVS_GRACE;
				else if (sw_store) next_st = NVS_STORE;
				else if (sw_recall) next_st = NVS_RECALL;
				else if (sw_sleep) next_st = NVS_SLEEP;
			end
			NVS_GRACE: next_st = NVS_STORE;
			NVS_STORE: if (cnt_end_store) next_st = NVS_RELEASE;
			NVS_RECALL: if (cnt_end_recall) next_st = NVS_IDLE;
			NVS_RELEASE: begin
				if (!drive_low || cnt_end_hhhd) next_st = NVS_IDLE;
			end
			NVS_SLEEP: if (cmd_evt) next_st = NVS_WAKE;
			NVS_WAKE: if (cnt_end_wake) next_st = NVS_IDLE;
		endcase
	end

	// State and duration counter
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			st <= NVS_IDLE;
			cnt <= '0;
		end else begin
			st <= next_st;
			cnt <= (next_st != st) ? '0 : cnt + 1'b1;
		end
	end

	// Written-since-copy flag; a write in the clearing cycle survives
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) dirty <= 1'b0;
		else dirty <= wr_evt || (dirty && !copy_start);
	end

	// Only stores we start ourselves pull the line; a pin store is held
	// low by its owner, and driving against it would fight the line
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) drive_low <= 1'b0;
		else if (st == NVS_IDLE && next_st != NVS_IDLE)
			drive_low <= !busy_ext_low;
	end

	// ----------------------------------------------------------------
	// Registered outputs, decoded from the next state
	// ----------------------------------------------------------------
	wire next_busy_low = next_st == NVS_STORE && drive_low;
	wire next_busy_high = next_st == NVS_RELEASE && drive_low;
	// Reads only when idle, supply good, line not held; writes then and in grace
	wire next_rd = next_st == NVS_IDLE && !vlow && !busy_ext_low;
	wire next_wr = next_rd || next_st == NVS_GRACE;
	wire next_lock = next_st == NVS_STORE || next_st == NVS_RECALL ||
		next_st == NVS_GRACE || next_st == NVS_WAKE;

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			hw_store_busy_line_out <= 1'b1;
			hw_store_busy_line_oe_b_out <= 1'b1;
			sram_rd_en_out <= 1'b0;
			sram_wr_en_out <= 1'b0;
			io_lockout_out <= 1'b0;
			nv_store_out <= 1'b0;
			nv_recall_out <= 1'b0;
			sleep_out <= 1'b0;
		end else begin
			hw_store_busy_line_out <= !next_busy_low;
			// Driver off except during our own store and release
			hw_store_busy_line_oe_b_out <= !(next_busy_low ||
				next_busy_high);
			sram_rd_en_out <= next_rd;
			sram_wr_en_out <= next_wr;
			io_lockout_out <= next_lock;
			nv_store_out <= next_st == NVS_STORE;
			nv_recall_out <= next_st == NVS_RECALL;
			sleep_out <= next_st == NVS_SLEEP;
		end
	end

	// Standby after STOP; any new command or copy wakes the front end
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) standby_out <= 1'b0;
		else if (cmd_evt || next_st != NVS_IDLE) standby_out <= 1'b0;
		else if (stop_evt) standby_out <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_grace;
		st == NVS_GRACE && sram_wr_en_out && !sram_rd_en_out;
	endsequence
	sequence s_store_on;
		st == NVS_STORE && nv_store_out && io_lockout_out;
	endsequence

	AST_SKIP_CLEAN: assert property (
		(st == NVS_IDLE && trig_req && !dirty && !sw_store) |=>
		!nv_store_out) else $error("store ran with nothing written");
	AST_GRACE: assert property (
		(st == NVS_IDLE && trig_store) |=> s_grace ##1 s_store_on)
		else $error("write grace window not one cycle then store");
	AST_IGNORE_RW: assert property (
		(nv_store_out || nv_recall_out || $past(vlow)) |->
		!sram_rd_en_out) else $error("access allowed while blocked");
	AST_STORE_LEN: assert property (
		nv_store_out |-> io_lockout_out && cnt < NVS_CNT_W'(STORE_CYC))
		else $error("store too long or unlocked");
	AST_RECALL_LEN: assert property (
		nv_recall_out |-> io_lockout_out && cnt < NVS_CNT_W'(RECALL_CYC))
		else $error("recall too long or unlocked");
	AST_CMD_ACT: assert property (
		(st == NVS_IDLE && sw_recall && !trig_store) |=>
		nv_recall_out) else $error("recall command not acted on");
	AST_SLEEP: assert property (
		(st == NVS_IDLE && sw_sleep && !trig_store) |=> sleep_out)
		else $error("sleep not entered");
	AST_WAKE: assert property (
		(st == NVS_WAKE) |-> io_lockout_out &&
		cnt < NVS_CNT_W'(WAKE_CYC)) else $error("wake time broken");
	AST_STANDBY: assert property (
		(stop_evt && !cmd_evt && next_st == NVS_IDLE) |=> standby_out)
		else $error("standby not entered after stop");
	AST_RESUME: assert property (
		($rose(busy_pin) && st == NVS_IDLE && next_st == NVS_IDLE &&
		!vlow) |=> sram_rd_en_out) else $error("no resume");
	AST_HIGH_DRIVE: assert property (
		(!hw_store_busy_line_oe_b_out && hw_store_busy_line_out) |->
		st == NVS_RELEASE && cnt < NVS_CNT_W'(NVS_HHHD_CYC))
		else $error("busy line driven high too long");
	AST_EXT_LOW: assert property (
		(st == NVS_IDLE && busy_ext_low) |=> !sram_rd_en_out &&
		hw_store_busy_line_oe_b_out) else $error("sram on under pin hold");
endmodule

// ### rtl/nvs_pkg.sv
package nvs_pkg;

	// ----------------------------------------------------------------
	// Clock rate
	// ----------------------------------------------------------------
	localparam int NVS_CLK_PERIOD_NS = 25;
	localparam int NVS_CLK_KHZ = 1000000 / NVS_CLK_PERIOD_NS;
	localparam int NVS_CLK_MHZ = NVS_CLK_KHZ / 1000;

	// ----------------------------------------------------------------
	// Timing figures, each in its own unit
	// ----------------------------------------------------------------
	localparam int NVS_T_STORE_MS = 8;
	localparam int NVS_T_RECALL_US = 600;
	localparam int NVS_T_SS_US = 500;
	localparam int NVS_T_SLEEP_MS = 8;
	localparam int NVS_T_WAKE_LV_MS = 40;
	localparam int NVS_T_WAKE_MS = 20;
	localparam int NVS_T_SB_US = 100;
	localparam int NVS_T_LZHSB_US = 5;
	localparam int NVS_T_HHHD_NS = 500;
	localparam int NVS_T_DELAY_NS = 25;

	// Longest times round down to whole cycles
	localparam int NVS_STORE_CYC = NVS_T_STORE_MS * NVS_CLK_KHZ;
	localparam int NVS_RECALL_CYC = NVS_T_RECALL_US * NVS_CLK_MHZ;
	localparam int NVS_SS_CYC = NVS_T_SS_US * NVS_CLK_MHZ;
	localparam int NVS_SLEEP_CYC = NVS_T_SLEEP_MS * NVS_CLK_KHZ;
	localparam int NVS_WAKE_LV_CYC = NVS_T_WAKE_LV_MS * NVS_CLK_KHZ;
	localparam int NVS_WAKE_CYC = NVS_T_WAKE_MS * NVS_CLK_KHZ;
	localparam int NVS_SB_CYC = NVS_T_SB_US * NVS_CLK_MHZ;
	localparam int NVS_LZHSB_CYC = NVS_T_LZHSB_US * NVS_CLK_MHZ;
	localparam int NVS_HHHD_CYC = NVS_T_HHHD_NS / NVS_CLK_PERIOD_NS;
	localparam int NVS_DELAY_CYC = NVS_T_DELAY_NS / NVS_CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Counter width and command codes
	// ----------------------------------------------------------------
	localparam int NVS_CNT_W = 21;
	localparam logic [1:0] NVS_CMD_STORE = 2'h0;
	localparam logic [1:0] NVS_CMD_RECALL = 2'h1;
	localparam logic [1:0] NVS_CMD_SLEEP = 2'h2;
	localparam logic [1:0] NVS_CMD_ACCESS = 2'h3;

	typedef enum logic [2:0] {
		NVS_IDLE,
		NVS_GRACE,
		NVS_STORE,
		NVS_RECALL,
		NVS_RELEASE,
		NVS_SLEEP,
		NVS_WAKE
	} nvs_state_t;

endpackage

// ### rtl/nvs_evt_sync.sv
`timescale 1ns/100ps
// Carries a one-cycle pulse from one clock domain to another by a toggle
module nvs_evt_sync (
	input wire logic src_clk_in,
	input wire logic src_rst_b_in,
	input wire logic src_pulse_in,
	input wire logic dst_clk_in,
	input wire logic dst_rst_b_in,
	output logic dst_pulse_out
);
	logic src_tgl;
	logic meta;
	logic sync;
	logic sync_d;

	// Source toggles once per event
	always_ff @(posedge src_clk_in) begin
		if (!src_rst_b_in) src_tgl <= 1'b0;
		else src_tgl <= src_tgl ^ src_pulse_in;
	end

	// Two flops, then an edge detect on the second one only
	always_ff @(posedge dst_clk_in) begin
		if (!dst_rst_b_in) begin
			meta <= 1'b0;
			sync <= 1'b0;
			sync_d <= 1'b0;
			dst_pulse_out <= 1'b0;
		end else begin
			meta <= src_tgl;
			sync <= meta;
			sync_d <= sync;
			dst_pulse_out <= sync ^ sync_d;
		end
	end
endmodule

// ### verif/nvs_host_model.sv
`timescale 1ns/100ps
// ------------------------------------------
// Link host: commands, writes and STOP
// ------------------------------------------
module nvs_host_model (
	output logic link_clk_out,
	output logic cmd_valid_out,
	output logic [1:0] cmd_code_out,
	output logic stop_out,
	output logic sram_wr_out
);
	// Clock rests low between frames, as the real host leaves it
	initial begin
		link_clk_out = 1'b0;
		cmd_valid_out = 1'b0;
		cmd_code_out = 2'h2;
		stop_out = 1'b0;
		sram_wr_out = 1'b0;
	end

	// Run n link cycles of 64 ns
	task automatic edges(input int n);
		repeat (n) begin
			#32 link_clk_out = 1'b1;
			#32 link_clk_out = 1'b0;
		end
	endtask

	// Gap first, so each event has three idle cycles to cross
	task automatic xfer(input logic v, input logic s, input logic w,
		input logic [1:0] c);
		edges(3);
		cmd_valid_out = v;
		cmd_code_out = c;
		stop_out = s;
		sram_wr_out = w;
		edges(1);
		cmd_valid_out = 1'b0;
		stop_out = 1'b0;
		sram_wr_out = 1'b0;
		cmd_code_out = ~c; // Released code line must not look valid
	endtask
endmodule

// ### verif/nvs_seq_tb.sv
`timescale 1ns/100ps
// ------------------------------------------
// Sequencer bench
// ------------------------------------------
module nvs_seq_tb import nvs_pkg::*;;
	localparam int STC = 50;
	localparam int RCC = 30;
	localparam int WKC = 40;
	logic sys_clk = 1'b0;
	logic rst_b, vcc_low, ext_low, busy_wire, link_clk, cmd_valid;
	logic stop, sram_wr, busy_out, oe_b, rd_en, wr_en, lock;
	logic st, rc, sb, sl, lbusy;
	logic [1:0] cmd_code;
	int fails = 0;
	int check_count = 0;

	// External pin pulls low; otherwise our driver or the pull-up
	assign busy_wire = ext_low ? 1'b0 : (oe_b ? 1'b1 : busy_out);

	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end

	nvs_host_model i_host (.link_clk_out(link_clk),
		.cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code),
		.stop_out(stop), .sram_wr_out(sram_wr));

	nvs_seq #(.STORE_CYC(STC), .RECALL_CYC(RCC), .WAKE_CYC(WKC)) i_dut (
		.sys_clk_in(sys_clk), .rst_b_in(rst_b), .link_clk_in(link_clk),
		.cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code),
		.stop_in(stop), .sram_wr_in(sram_wr), .vcc_low_in(vcc_low),
		.hw_store_busy_line_in(busy_wire),
		.hw_store_busy_line_out(busy_out),
		.hw_store_busy_line_oe_b_out(oe_b), .sram_rd_en_out(rd_en),
		.sram_wr_en_out(wr_en), .io_lockout_out(lock),
		.nv_store_out(st), .nv_recall_out(rc), .standby_out(sb),
		.sleep_out(sl), .link_busy_out(lbusy));

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %0d seen %0d", name, exp, seen);
		end
	endtask

	task automatic complete_run();
		if (fails == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Bounded wait; running out counts as a mismatch and ends the run
	task automatic wait_for(ref logic s, input logic v, input int lim,
		input string name);
		int i;
		i = 0;
		while (s !== v) begin
			if (i == lim) begin
				check(name, s, v);
				complete_run();
			end
			@(negedge sys_clk);
			i++;
		end
	endtask

	task automatic count_hi(ref logic s, output int n);
		n = 0;
		while (s === 1'b1 && n < 5000) begin
			@(negedge sys_clk);
			n++;
		end
	endtask

	task automatic t_store();
		int n;
		i_host.xfer(1'b1, 1'b0, 1'b0, NVS_CMD_STORE);
		@(negedge sys_clk);
		wait_for(st, 1'b1, 40, "store start");
		check("lockout", lock, 1'b1);
		check("rd_en", rd_en, 1'b0);
		check("wr_en", wr_en, 1'b0);
		// Link side must see the lockout while the store runs
		fork
			count_hi(st, n);
			begin
				i_host.edges(3);
				check("link busy", lbusy, 1'b1);
			end
		join
		check("store cycles", n, STC);
		while (oe_b === 1'b0 && busy_out === 1'b1 && n < 99) begin
			@(negedge sys_clk);
			n++;
		end
		check("high drive", n - STC, NVS_HHHD_CYC);
		check("driver off", oe_b, 1'b1);
		wait_for(rd_en, 1'b1, NVS_LZHSB_CYC, "resume");
		check("lockout end", lock, 1'b0);
		i_host.edges(3);
		check("link idle", lbusy, 1'b0);
	endtask

	task automatic t_recall();
		int n;
		i_host.xfer(1'b1, 1'b0, 1'b0, NVS_CMD_RECALL);
		@(negedge sys_clk);
		wait_for(rc, 1'b1, 40, "recall start");
		check("rd_en", rd_en, 1'b0);
		count_hi(rc, n);
		check("recall cycles", n, RCC);
		wait_for(lock, 1'b0, 4, "recall end");
	endtask

	// Power-down or pin trigger, with or without a prior write
	task automatic t_trig(input logic pin, input logic dirty);
		int n;
		if (dirty) begin
			i_host.xfer(1'b0, 1'b0, 1'b1, 2'h3);
		end
		repeat (6) @(negedge sys_clk);
		ext_low = pin;
		vcc_low = ~pin;
		if (dirty) begin
			wait_for(lock, 1'b1, 6, "grace");
			check("grace wr_en", wr_en, 1'b1);
			check("grace rd_en", rd_en, 1'b0);
			@(negedge sys_clk);
			check("store", st, 1'b1);
			check("wr_en", wr_en, 1'b0);
			check("pin driver", oe_b, pin);
			count_hi(st, n);
			check("store cycles", n, STC);
			wait_for(lock, 1'b0, 40, "store end");
		end else begin
			repeat (8) @(negedge sys_clk);
			check("clean store", st, 1'b0);
			check("clean lockout", lock, 1'b0);
		end
		check("rd_en held", rd_en, 1'b0);
		ext_low = 1'b0;
		vcc_low = 1'b0;
		wait_for(rd_en, 1'b1, NVS_LZHSB_CYC, "resume");
	endtask

	task automatic t_sleep();
		int n;
		i_host.xfer(1'b1, 1'b0, 1'b0, NVS_CMD_SLEEP);
		@(negedge sys_clk);
		wait_for(sl, 1'b1, 40, "sleep");
		i_host.xfer(1'b1, 1'b0, 1'b0, NVS_CMD_ACCESS);
		@(negedge sys_clk);
		wait_for(lock, 1'b1, 40, "wake");
		check("sleep left", sl, 1'b0);
		count_hi(lock, n); // Host waits out the wake time
		check("wake cycles", n, WKC);
	endtask

	task automatic t_standby();
		i_host.xfer(1'b0, 1'b1, 1'b0, 2'h3);
		@(negedge sys_clk);
		wait_for(sb, 1'b1, 40, "standby");
		i_host.xfer(1'b1, 1'b0, 1'b0, NVS_CMD_ACCESS);
		@(negedge sys_clk);
		wait_for(sb, 1'b0, 40, "standby exit");
	endtask

	// Link side needs its own edges during reset
	initial begin
		rst_b = 1'b0;
		vcc_low = 1'b0;
		ext_low = 1'b0;
		fork
			repeat (16) @(negedge sys_clk);
			i_host.edges(4);
		join
		check("reset busy", busy_out, 1'b1);
		check("reset oe_b", oe_b, 1'b1);
		rst_b = 1'b1;
		wait_for(rd_en, 1'b1, 4, "ready");
		t_store();
		t_recall();
		t_trig(1'b0, 1'b0);
		t_trig(1'b0, 1'b1);
		t_trig(1'b1, 1'b1);
		t_trig(1'b1, 1'b0);
		t_sleep();
		t_standby();
		complete_run();
	end
endmodule
